// ==== logic/sif_consts.vh ====
// constants of the sensor i2c fetch block
`ifndef SIF_CONSTS_VH
`define SIF_CONSTS_VH

// ----------------------------------------------------------------
// bus address
// ----------------------------------------------------------------
`define SIF_ADDR_RESET   7'h28

// ----------------------------------------------------------------
// status codes, top two bits of the first byte
// ----------------------------------------------------------------
`define SIF_ST_VALID     2'h0
`define SIF_ST_CMD       2'h1
`define SIF_ST_STALE     2'h2
`define SIF_ST_FAULT     2'h3

// ----------------------------------------------------------------
// pressure scale, counts at rated minimum and maximum
// ----------------------------------------------------------------
`define SIF_P_MIN_COUNTS 14'h0666
`define SIF_P_MAX_COUNTS 14'h3999

// ----------------------------------------------------------------
// widths, depths, counts and reset values
// ----------------------------------------------------------------
`define SIF_P_W          14
`define SIF_T_W          11
`define SIF_WORD_W       26
`define SIF_PKT_W        27
`define SIF_FIFO_DEPTH   4
`define SIF_FIFO_AW      2
`define SIF_BITS_ADDR    4'h8
`define SIF_BIT_LAST     4'h7
`define SIF_BYTE_LAST    2'h3
`define SIF_TEMP_RESET   11'h000
`define SIF_SYNC_RESET   3'h7

`endif

// ==== logic/sif_i2c_fetch.v ====
// i2c target read path of a pressure/temperature sensor, with measurement fifo
//
// Function
// - Acknowledge only the configured 7-bit address, 28 hex by default.
// - Read starts with address plus direction bit 1; device answers with ACK.
// - Bytes go out in order while the controller acknowledges; NACK and stop end. Here the fourth byte ends the read even if acknowledged.
// - Byte one: two status bits then pressure 13:8; byte two: pressure 7:0.
// - Acknowledged second byte is followed by temperature bits 10:3.
// - Acknowledged third byte is followed by temperature 2:0 on top, rest masked.
// - Temperature is 11 bits; four bytes give all, three give upper eight.
// - Pressure counts run typically from 1638 at minimum to 14745 at maximum.
// - Start then stop without clock pulses spoils the next transaction.
// - Status 00 fresh, 01 command mode, 10 stale, 11 diagnostic fault.
// - A fault shows in the next fetch and stays until power-on reset.
// - Repeated start during a transfer makes that transaction fail.
`timescale 1ns/100ps
`default_nettype none
`include "sif_consts.vh"

// ----------------------------------------------------------------
// measurement fifo
// ----------------------------------------------------------------
module sif_fifo #(
	parameter W  = `SIF_WORD_W,
	parameter D  = `SIF_FIFO_DEPTH,
	parameter AW = `SIF_FIFO_AW
) (
	// clock and reset
	input  wire         mclk,
	input  wire         rst,
	// filling side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// draining side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	localparam [AW:0] DEPTH_N = D[AW:0];

	reg  [W-1:0] mem_r [0:D-1];
	reg  [AW-1:0] wp_r;
	reg  [AW-1:0] rp_r;
	reg  [AW:0]   cnt_r;
	wire          push;
	wire          pop;

	assign in_ready  = (cnt_r != DEPTH_N);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage has no reset; only words below the count are ever read
	always @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_r <= (wp_r == DEPTH_N[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == DEPTH_N[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------------------------------
// i2c target, read-only measurement fetch
// ----------------------------------------------------------------
module sif_i2c_fetch #(
	parameter [6:0] TARGET_ADDR = `SIF_ADDR_RESET
) (
	// clock and reset
	input  wire                  mclk,
	input  wire                  rst,
	// i2c pins, open drain
	input  wire                  scl_in,
	input  wire                  sda_in,
	output wire                  sda_out,
	output wire                  sda_oe,
	// measurement stream from the conditioning logic
	input  wire                  meas_valid,
	output wire                  meas_ready,
	input  wire [`SIF_P_W-1:0]   meas_pressure,
	input  wire [`SIF_T_W-1:0]   meas_temp,
	input  wire                  meas_fault,
	// mode level
	input  wire                  cmd_mode
);
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_ADDR   = 3'h1;
	localparam [2:0] ST_AACK   = 3'h2;
	localparam [2:0] ST_TX     = 3'h3;
	localparam [2:0] ST_TXACK  = 3'h4;
	localparam [2:0] ST_IGNORE = 3'h5;

	// ----------------------------------------------------------------
	// packet byte select
	// ----------------------------------------------------------------
	function [7:0] pkt_byte;
		input [`SIF_PKT_W-1:0] pkt;
		input [1:0]            idx;
		begin
			case (idx)
				2'h0:    pkt_byte = pkt[26:19];
				2'h1:    pkt_byte = pkt[18:11];
				2'h2:    pkt_byte = pkt[10:3];
				default: pkt_byte = {pkt[2:0], 5'h00};
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg  [2:0] scl_s_r;
	reg  [2:0] sda_s_r;
	reg        scl_q_r;
	reg        scl_d_r;
	reg        sda_q_r;
	reg        sda_d_r;

	// a level counts only once stages two and three agree
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_s_r <= `SIF_SYNC_RESET;
			sda_s_r <= `SIF_SYNC_RESET;
			scl_q_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_q_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[1:0], scl_in};
			sda_s_r <= {sda_s_r[1:0], sda_in};
			if (scl_s_r[1] == scl_s_r[2]) begin
				scl_q_r <= scl_s_r[2];
			end
			if (sda_s_r[1] == sda_s_r[2]) begin
				sda_q_r <= sda_s_r[2];
			end
			scl_d_r <= scl_q_r;
			sda_d_r <= sda_q_r;
		end
	end

	wire scl_rise = scl_q_r & ~scl_d_r;
	wire scl_fall = ~scl_q_r & scl_d_r;
	wire bus_start = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
	wire bus_stop  = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;

	// ----------------------------------------------------------------
	// measurement intake
	// ----------------------------------------------------------------
	reg  [2:0]             state_r;
	wire                   fifo_valid;
	wire [`SIF_WORD_W-1:0] fifo_data;
	// drain only while idle so the held measurement never changes mid packet
	wire                   fifo_take = (state_r == ST_IDLE);

	sif_fifo #(
		.W  (`SIF_WORD_W),
		.D  (`SIF_FIFO_DEPTH),
		.AW (`SIF_FIFO_AW)
	) sif_fifo_inst (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (meas_valid),
		.in_ready  (meas_ready),
		.in_data   ({meas_fault, meas_pressure, meas_temp}),
		.out_valid (fifo_valid),
		.out_ready (fifo_take),
		.out_data  (fifo_data)
	);

	reg  [`SIF_P_W-1:0]   press_r;
	reg  [`SIF_T_W-1:0]   temp_r;
	reg                   fresh_r;
	reg                   fault_r;
	reg  [`SIF_PKT_W-1:0] pkt_r;
	wire [1:0]            status_nxt;

	assign status_nxt = fault_r  ? `SIF_ST_FAULT :
	                    cmd_mode ? `SIF_ST_CMD   :
	                    fresh_r  ? `SIF_ST_VALID :
	                               `SIF_ST_STALE;

	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	reg  [3:0] bitcnt_r;
	reg  [7:0] shift_r;
	reg  [1:0] byte_idx_r;
	reg        acked_r;
	reg        saw_clk_r;
	reg        poison_r;
	reg        oe_r;
	wire [1:0] byte_idx_nxt = byte_idx_r + 2'h1;
	wire [7:0] byte_nxt     = pkt_byte(pkt_r, byte_idx_nxt);
	wire [7:0] byte_first   = pkt_byte(pkt_r, 2'h0);
	wire       busy = (state_r == ST_ADDR) | (state_r == ST_AACK) |
	                  (state_r == ST_TX) | (state_r == ST_TXACK);
	wire       load = fifo_valid & fifo_take;
	wire       addr_ok = (bitcnt_r == `SIF_BITS_ADDR) &&
	                     (shift_r[7:1] == TARGET_ADDR) && shift_r[0];

	assign sda_out = 1'b0;
	assign sda_oe  = oe_r;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r    <= ST_IDLE;
			bitcnt_r   <= 4'h0;
			shift_r    <= 8'h00;
			byte_idx_r <= 2'h0;
			acked_r    <= 1'b0;
			saw_clk_r  <= 1'b0;
			poison_r   <= 1'b0;
			oe_r       <= 1'b0;
			press_r    <= `SIF_P_MIN_COUNTS;
			temp_r     <= `SIF_TEMP_RESET;
			fresh_r    <= 1'b0;
			fault_r    <= 1'b0;
			pkt_r      <= {`SIF_PKT_W{1'b0}};
		end else begin
			// pressure counts arrive already scaled to the rated span
			if (load) begin
				press_r <= fifo_data[24:11];
				temp_r  <= fifo_data[10:0];
				fresh_r <= 1'b1;
				if (fifo_data[25]) begin
					fault_r <= 1'b1;
				end
			end
			if (scl_rise) begin
				saw_clk_r <= 1'b1;
			end
			if (bus_start) begin
				saw_clk_r <= 1'b0;
				bitcnt_r  <= 4'h0;
				oe_r      <= 1'b0;
				if (busy) begin
					state_r <= ST_IGNORE;
				end else if (poison_r) begin
					state_r  <= ST_IGNORE;
					poison_r <= 1'b0;
				end else begin
					state_r <= ST_ADDR;
				end
			end else if (bus_stop) begin
				state_r <= ST_IDLE;
				oe_r    <= 1'b0;
				if (!saw_clk_r && state_r != ST_IDLE) begin
					poison_r <= 1'b1;
				end
			end else begin
				case (state_r)
					ST_ADDR: begin
						if (scl_rise) begin
							shift_r  <= {shift_r[6:0], sda_q_r};
							bitcnt_r <= bitcnt_r + 4'h1;
						end else if (scl_fall && bitcnt_r == `SIF_BITS_ADDR) begin
							if (addr_ok) begin
								state_r <= ST_AACK;
								oe_r    <= 1'b1;
								pkt_r   <= {status_nxt, press_r, temp_r};
								fresh_r <= load;
							end else begin
								state_r <= ST_IGNORE;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							state_r    <= ST_TX;
							shift_r    <= byte_first;
							oe_r       <= ~byte_first[7];
							byte_idx_r <= 2'h0;
							bitcnt_r   <= 4'h0;
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (bitcnt_r == `SIF_BIT_LAST) begin
								state_r <= ST_TXACK;
								oe_r    <= 1'b0;
							end else begin
								shift_r  <= {shift_r[6:0], 1'b0};
								oe_r     <= ~shift_r[6];
								bitcnt_r <= bitcnt_r + 4'h1;
							end
						end
					end
					ST_TXACK: begin
						if (scl_rise) begin
							acked_r <= ~sda_q_r;
						end else if (scl_fall) begin
							if (acked_r && byte_idx_r != `SIF_BYTE_LAST) begin
								state_r    <= ST_TX;
								byte_idx_r <= byte_idx_nxt;
								shift_r    <= byte_nxt;
								oe_r       <= ~byte_nxt[7];
								bitcnt_r   <= 4'h0;
							end else begin
								state_r <= ST_IGNORE;
							end
						end
					end
					ST_IGNORE: begin
						oe_r <= 1'b0;
					end
					default: begin
						oe_r <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/sif_i2c_fetch_asserts.sv ====
// assertion checker for the i2c fetch target
`timescale 1ns/100ps
`default_nettype none
module sif_i2c_fetch_asserts #(
	parameter [6:0] TARGET_ADDR = 7'h28
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins and stream handshake
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic meas_ready
);
	logic       scl_r, sda_r, fr_r, pz_r, bad_r;
	logic [3:0] bc_r;
	logic [2:0] by_r;
	logic [6:0] sh_r;
	wire        st = scl_r & scl_in & sda_r & ~sda_in;
	wire        sp = scl_r & scl_in & ~sda_r & sda_in;
	wire        ri = ~scl_r & scl_in & fr_r;
	wire        idle = bc_r == 4'h0 & by_r == 3'h0;
	wire        hit = ri & by_r == 3'h0 & bc_r == 4'h7 & {sh_r, sda_in} == {TARGET_ADDR, 1'b1};

	// --------------------
	// frame tracker
	// --------------------
	// refused, nacked or poisoned frames hold bad_r until the next start
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			fr_r  <= 1'b0;
			pz_r  <= 1'b0;
			bad_r <= 1'b0;
			bc_r  <= 4'h0;
			by_r  <= 3'h0;
			sh_r  <= 7'h00;
		end else begin
			scl_r <= scl_in;
			sda_r <= sda_in;
			if (st) begin
				fr_r  <= 1'b1;
				bad_r <= pz_r | fr_r;
				pz_r  <= 1'b0;
				bc_r  <= 4'h0;
				by_r  <= 3'h0;
			end else if (sp & fr_r) begin
				fr_r <= 1'b0;
				pz_r <= idle;
			end else if (ri) begin
				sh_r <= {sh_r[5:0], sda_in};
				bc_r <= (bc_r == 4'h8) ? 4'h0 : bc_r + 4'h1;
				if (bc_r == 4'h8)
					by_r <= by_r + 3'h1;
				if ((bc_r == 4'h7 & by_r == 3'h0 & ~hit) | (bc_r == 4'h8 & by_r != 3'h0 & sda_in))
					bad_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence ack_s;
		##[1:20] sda_oe;
	endsequence
	sequence held_s;
		fr_r & ~idle & ~meas_ready;
	endsequence

	drive_zero_a:
		assert property (sda_out == 1'b0) else $error("sda data not zero");
	oe_scl_low_a:
		assert property ($changed(sda_oe) |-> ~scl_in) else $error("sda drive moved with scl high");
	idle_quiet_a:
		assert property (~fr_r |-> ~sda_oe) else $error("sda driven outside a frame");
	addr_ack_a:
		assert property (hit & ~bad_r |-> ack_s) else $error("own address not acked");
	refuse_quiet_a:
		assert property (bad_r |-> ~sda_oe) else $error("sda driven in refused frame");
	ack_free_a:
		assert property (ri & bc_r == 4'h8 & by_r != 3'h0 |-> ~sda_oe) else $error("ack slot not free");
	fifo_hold_a:
		assert property (held_s |=> ~meas_ready) else $error("fifo drained in a frame");
	reset_idle_a:
		assert property ($fell(rst) |-> meas_ready & ~sda_oe) else $error("bad state after reset");
endmodule

bind sif_i2c_fetch sif_i2c_fetch_asserts #(.TARGET_ADDR(TARGET_ADDR)) sif_i2c_fetch_asserts_inst (
	.mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.meas_ready(meas_ready));
`default_nettype wire

// ==== testbench/sif_ctl.sv ====
// i2c controller model fetching measurement packets
`timescale 1ns/100ps
`default_nettype none
module sif_ctl (
	// bus drive
	output logic     scl,
	output logic     oe,
	// resolved sda
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		oe  = 1'b0;
	end
	// 125 ns bit: low 65, high 60, sda sampled late in the high phase
	task automatic bit_io(input logic b, output logic s);
		scl = 1'b0;
		#30 oe = ~b;
		#35 scl = 1'b1;
		#55 s = sda;
		#5;
	endtask
	// a held-low sda is lifted with scl low so no stop slips out
	task automatic start;
		if (oe) begin
			scl = 1'b0;
			#30 oe = 1'b0;
			#35 scl = 1'b1;
		end
		#60 oe = 1'b1;
		#65;
	endtask
	task automatic stop;
		scl = 1'b0;
		#30 oe = 1'b1;
		#35 scl = 1'b1;
		#60 oe = 1'b0;
		#2000;
	endtask
	// stop straight after a start, scl held high throughout so no clock pulse slips in
	task automatic bare_stop;
		#600 oe = 1'b0;
		#2000;
	endtask
	// ack 0 acknowledges, 1 ends the packet
	task automatic xfer(input logic [7:0] w, input logic ack, output logic [7:0] r, output logic got);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(ack, got);
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_sif_i2c_fetch.sv ====
// self-checking bench for the i2c fetch target
`timescale 1ns/100ps
`default_nettype none
module tb_sif_i2c_fetch;
	logic        mclk, rst, scl, ctl_oe, sda_out, sda_oe, g;
	logic        meas_valid, meas_ready, meas_fault, cmd_mode;
	logic [13:0] meas_pressure;
	logic [10:0] meas_temp;
	logic [7:0]  rb [4];
	int          n_mismatch, total_checks;
	wire         sda = ~(sda_oe | ctl_oe);

	sif_i2c_fetch sif_i2c_fetch_inst (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .meas_valid(meas_valid), .meas_ready(meas_ready), .meas_pressure(meas_pressure),
		.meas_temp(meas_temp), .meas_fault(meas_fault), .cmd_mode(cmd_mode));
	sif_ctl sif_ctl_inst (.scl(scl), .oe(ctl_oe), .sda(sda));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [13:0] p, input logic [10:0] t, input logic f);
		@(posedge mclk);
		meas_valid    <= 1'b1;
		meas_pressure <= p;
		meas_temp     <= t;
		meas_fault    <= f;
		do @(negedge mclk); while (meas_ready !== 1'b1);
		@(posedge mclk);
		meas_valid <= 1'b0;
	endtask
	// n bytes, the last one nacked
	task automatic fetch(input logic [7:0] a, input int n, input logic ack_exp);
		sif_ctl_inst.start();
		sif_ctl_inst.xfer(a, 1'b1, rb[0], g);
		check("addr ack", {7'h0, ~g}, {7'h0, ack_exp});
		for (int i = 0; i < n && g === 1'b0; i++)
			sif_ctl_inst.xfer(8'hff, i == n - 1, rb[i], g);
		sif_ctl_inst.stop();
	endtask
	task automatic t_refuse;
		fetch(8'h53, 1, 1'b0);
		fetch(8'h50, 1, 1'b0);
		sif_ctl_inst.start();
		sif_ctl_inst.bare_stop();
		fetch(8'h51, 1, 1'b0);
		// repeated start while the address is still being shifted in
		sif_ctl_inst.start();
		sif_ctl_inst.bit_io(1'b0, g);
		sif_ctl_inst.bit_io(1'b1, g);
		fetch(8'h51, 1, 1'b0);
		fetch(8'h51, 1, 1'b1);
		check("reset pkt", rb[0], 8'h86);
	endtask
	task automatic t_full;
		put(14'h3999, 11'h5a5, 1'b0);
		fetch(8'h51, 4, 1'b1);
		check("b0", rb[0], 8'h39);
		check("b1", rb[1], 8'h99);
		check("b2", rb[2], 8'hb4);
		check("b3", rb[3] & 8'he0, 8'ha0);
		fetch(8'h51, 3, 1'b1);
		check("stale", rb[0], 8'hb9);
		check("t high", rb[2], 8'hb4);
	endtask
	// the controller stalls mid-frame while the fifo fills
	task automatic t_fill;
		sif_ctl_inst.start();
		sif_ctl_inst.xfer(8'h51, 1'b1, rb[0], g);
		for (int i = 0; i < 4; i++)
			put(14'(256 + i), 11'h000, 1'b0);
		@(negedge mclk);
		check("full", {7'h0, meas_ready}, 8'h00);
		sif_ctl_inst.xfer(8'hff, 1'b1, rb[0], g);
		check("held pkt", rb[0], 8'hb9);
		sif_ctl_inst.stop();
		fetch(8'h51, 2, 1'b1);
		check("fresh", rb[0], 8'h01);
		check("last word", rb[1], 8'h03);
	endtask
	task automatic t_status;
		@(posedge mclk);
		cmd_mode <= 1'b1;
		fetch(8'h51, 1, 1'b1);
		check("cmd", rb[0] & 8'hc0, 8'h40);
		put(14'h0666, 11'h000, 1'b1);
		fetch(8'h51, 1, 1'b1);
		check("fault", rb[0], 8'hc6);
		@(posedge mclk);
		cmd_mode <= 1'b0;
		put(14'h3999, 11'h000, 1'b0);
		fetch(8'h51, 1, 1'b1);
		check("fault kept", rb[0], 8'hf9);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// runs take about 60 us
	initial begin
		#400000;
		n_mismatch++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		meas_valid = 1'b0;
		meas_fault = 1'b0;
		meas_pressure = 14'h0000;
		meas_temp = 11'h000;
		cmd_mode = 1'b0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (5) @(posedge mclk);
		t_refuse();
		t_full();
		t_fill();
		t_status();
		test_done();
	end
endmodule
`default_nettype wire
